// [dfe_can_master_model.sv]
// Behavioural CAN-side master that takes emergency frames
`timescale 1ns/1ps
`default_nettype none
module dfe_can_master_model (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  delay,
  input  wire logic        emcy_req,
  input  wire logic [7:0]  emcy_b0,
  input  wire logic [7:0]  emcy_b1,
  output logic             emcy_sent,
  output logic [15:0]      last_code
);
  logic [3:0]  wait_cnt;
  logic [15:0] done_code;
  // One frame per new code; a code still held is not sent twice
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      emcy_sent <= 1'b0;
      last_code <= 16'h0000;
      done_code <= 16'h0000;
      wait_cnt  <= 4'h0;
    end else if (emcy_sent) begin
      emcy_sent <= 1'b0;
    end else if (!emcy_req) begin
      done_code <= 16'h0000;
      wait_cnt  <= 4'h0;
    end else if ({emcy_b1, emcy_b0} != done_code) begin
      if (wait_cnt >= delay) begin
        emcy_sent <= 1'b1;
        last_code <= {emcy_b1, emcy_b0};
        done_code <= {emcy_b1, emcy_b0};
        wait_cnt  <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : dfe_can_master_model
`default_nettype wire

// [dfe_pkg.sv]
// Package of constants for the drive fault and emergency reporter
package dfe_pkg;
  localparam logic [15:0] EMCY_DUP_ID    = 16'h8150;
  localparam logic [15:0] EMCY_FOLLOW    = 16'h8611;
  localparam logic [15:0] EMCY_RAMP      = 16'h8612;
  localparam logic [15:0] EMCY_NONE      = 16'h0000;
  localparam int          SW_FAULT_BIT   = 3;
  localparam int          SW_FOLLOW_BIT  = 13;
  localparam int          NODE_BITS      = 7;
  localparam int          HIST_DEPTH     = 8;
  // Register offsets (word addresses on the plain port)
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h1;
  localparam logic [3:0]  REG_IRQ_STAT   = 4'h2;
  localparam logic [3:0]  REG_IRQ_EN     = 4'h3;
  localparam logic [3:0]  REG_IRQ_CLR    = 4'h4;
  localparam logic [3:0]  REG_FE_WINDOW  = 4'h5;
  localparam logic [3:0]  REG_FE_TIMEOUT = 4'h6;
  localparam logic [3:0]  REG_HIST_CNT   = 4'h7;
  localparam logic [3:0]  REG_HIST_BASE  = 4'h8;
  // Field positions
  localparam int          CTRL_REACT_LSB = 0;
  localparam int          CTRL_FCLR_BIT  = 8;
  localparam int          IRQ_DUP_BIT    = 0;
  localparam int          IRQ_FOLLOW_BIT = 1;
  localparam int          IRQ_RAMP_BIT   = 2;
  // Reset values
  localparam logic [31:0] FE_WINDOW_RST  = 32'h0000_0100;
  localparam logic [15:0] FE_TIMEOUT_RST = 16'h000a;
  localparam logic [2:0]  IRQ_EN_RST     = 3'h0;
  localparam logic [2:0]  REACT_RST      = 3'h0;
endpackage : dfe_pkg

// [dfe_reporter.sv]
// Fault and emergency reporter of a networked positioning drive
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Block receive on duplicate COB-ID, emergency 8150
// - Conflict on SDO write or power-on load
// - Power-on load replaces low seven bits
// - Clear 8150 once emergency sent
// - Following error beyond timeout gives 8611
// - Apply configured fault reaction on 8611
// - Set status bits 13 and 3
// - Clear bits and 8611 on fault clear
// - Refuse out-of-range ramp, warning 8612
// - Clear 8612 after handshake and ack low
// - Incremental distance not below stroke warns
// - Wide soft limits wrap instead of warning
// - Record emergency codes in history
module dfe_reporter
  import dfe_pkg::*;
#(
  parameter int ID_W = 11,
  parameter int POS_W = 32
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  input  wire logic              id_wr,
  input  wire logic              id_load,
  input  wire logic [ID_W-1:0]   id_value,
  input  wire logic [NODE_BITS-1:0] node_addr,
  input  wire logic              id_conflict,
  output logic [ID_W-1:0]        id_eff,
  output logic                   rx_block,
  input  wire logic              emcy_sent,
  output logic                   emcy_req,
  output logic [7:0]             emcy_b0,
  output logic [7:0]             emcy_b1,
  input  wire logic signed [POS_W-1:0] follow_err,
  input  wire logic              ramp_req,
  input  wire logic              ramp_ack,
  input  wire logic              incr_mode,
  input  wire logic signed [POS_W-1:0] ramp_target,
  input  wire logic signed [POS_W-1:0] ramp_dist,
  input  wire logic signed [POS_W-1:0] stroke,
  input  wire logic signed [POS_W-1:0] range_min,
  input  wire logic signed [POS_W-1:0] range_max,
  input  wire logic signed [POS_W-1:0] soft_min,
  input  wire logic signed [POS_W-1:0] soft_max,
  output logic                   ramp_refuse,
  output logic signed [POS_W-1:0] ramp_dest,
  output logic [15:0]            status_word,
  output logic [2:0]             fault_react,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic outside(input logic signed [POS_W-1:0] v,
                                   input logic signed [POS_W-1:0] lo,
                                   input logic signed [POS_W-1:0] hi);
    outside = (v < lo) || (v > hi);
  endfunction : outside

  function automatic logic [POS_W-1:0] absval(
    input logic signed [POS_W-1:0] v);
    absval = v[POS_W-1] ? POS_W'(-v) : POS_W'(v);
  endfunction : absval

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [ID_W-1:0]  id_eff_reg, id_eff_next;
  logic             rx_block_reg, rx_block_next;
  logic             dup_reg, dup_next;
  logic             follow_reg, follow_next;
  logic             ramp_warn_reg, ramp_warn_next;
  logic             ramp_done_reg, ramp_done_next;
  logic             refuse_reg, refuse_next;
  logic signed [POS_W-1:0] dest_reg, dest_next;
  logic [15:0]      fe_cnt_reg, fe_cnt_next;
  logic [31:0]      fe_win_reg, fe_win_next;
  logic [15:0]      fe_to_reg, fe_to_next;
  logic [2:0]       react_reg, react_next;
  logic [2:0]       ien_reg, ien_next;
  logic [2:0]       ist_reg, ist_next;
  logic [15:0]      code_reg, code_next;
  logic             emcy_reg, emcy_next;
  logic [15:0]      hist_reg [HIST_DEPTH];
  logic [15:0]      hist_cnt_reg, hist_cnt_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic             dup_set, follow_set, ramp_set, fault_clr, hist_push;
  logic [15:0]      push_code;
  logic             ramp_bad;
  logic signed [POS_W-1:0] wrapped;

  // ----------------------------------------------------------------
  // Event logic
  // ----------------------------------------------------------------
  always_comb begin
    id_eff_next   = id_eff_reg;
    rx_block_next = rx_block_reg;
    dup_set       = 1'b0;
    if (id_load)
      id_eff_next = {id_value[ID_W-1:NODE_BITS], node_addr};
    else if (id_wr)
      id_eff_next = id_value;
    if (id_wr || id_load) begin
      rx_block_next = id_conflict;
      dup_set       = id_conflict;
    end
    // Soft limits no tighter than range limits: wrap target instead
    wrapped = ramp_target;
    if (ramp_target > range_max) begin
      wrapped = range_min + (ramp_target - range_max);
    end else if (ramp_target < range_min) begin
      wrapped = range_max - (range_min - ramp_target);
    end
    ramp_bad = outside(ramp_target, range_min, range_max) ||
               outside(ramp_target, soft_min, soft_max);
    if (soft_min <= range_min && soft_max >= range_max) begin
      ramp_bad = 1'b0;
    end
    if (incr_mode && absval(ramp_dist) >= absval(stroke)) begin
      ramp_bad = 1'b1;
    end
    ramp_set    = ramp_req && ramp_bad && !ramp_warn_reg;
    refuse_next = ramp_req ? ramp_bad : refuse_reg;
    dest_next   = dest_reg;
    if (ramp_req && !ramp_bad) dest_next = wrapped;
    // Warning held until handshake over and ack back low
    ramp_done_next = ramp_done_reg;
    ramp_warn_next = ramp_warn_reg;
    if (ramp_set) begin
      ramp_warn_next = 1'b1;
      ramp_done_next = 1'b0;
    end else if (ramp_warn_reg) begin
      if (ramp_ack) ramp_done_next = 1'b1;
      if (ramp_done_reg && !ramp_ack && !ramp_req)
        ramp_warn_next = 1'b0;
    end
    // Following error window and timeout
    fault_clr   = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_FCLR_BIT];
    fe_cnt_next = fe_cnt_reg;
    if (absval(follow_err) > fe_win_reg) begin
      if (fe_cnt_reg != 16'hffff) fe_cnt_next = fe_cnt_reg + 16'h0001;
    end else begin
      fe_cnt_next = 16'h0000;
    end
    follow_set  = !follow_reg && fe_cnt_reg > fe_to_reg;
    follow_next = follow_reg;
    if (follow_set) begin
      follow_next = 1'b1;
    end else if (fault_clr) begin
      follow_next = 1'b0;
      fe_cnt_next = 16'h0000;
    end
    // Duplicate-id emergency dropped right after its transmission
    dup_next = dup_reg;
    if (dup_set)
      dup_next = 1'b1;
    else if (emcy_sent && emcy_reg && code_reg == EMCY_DUP_ID)
      dup_next = 1'b0;
    // Priority of the reported code: fault, conflict, warning
    code_next = EMCY_NONE;
    if (follow_next)
      code_next = EMCY_FOLLOW;
    else if (dup_next)
      code_next = EMCY_DUP_ID;
    else if (ramp_warn_next)
      code_next = EMCY_RAMP;
    emcy_next = dup_next || (follow_next && !follow_reg) || ramp_set ||
                (emcy_reg && !emcy_sent && code_next != EMCY_NONE);
    hist_push = dup_set || follow_set || ramp_set;
    push_code = follow_set ? EMCY_FOLLOW :
                dup_set ? EMCY_DUP_ID : EMCY_RAMP;
    hist_cnt_next = hist_cnt_reg;
    if (hist_push && hist_cnt_reg != 16'hffff)
      hist_cnt_next = hist_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    fe_win_next = fe_win_reg;
    fe_to_next  = fe_to_reg;
    react_next  = react_reg;
    ien_next    = ien_reg;
    // Set wins over a same-cycle clear
    ist_next    = ist_reg;
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:       react_next  = reg_wdata[CTRL_REACT_LSB +: 3];
        REG_IRQ_EN:     ien_next    = reg_wdata[2:0];
        REG_IRQ_CLR:    ist_next    = ist_reg & ~reg_wdata[2:0];
        REG_FE_WINDOW:  fe_win_next = reg_wdata;
        REG_FE_TIMEOUT: fe_to_next  = reg_wdata[15:0];
        default:        ;
      endcase
    end
    ist_next[IRQ_DUP_BIT]    = ist_next[IRQ_DUP_BIT] | dup_set;
    ist_next[IRQ_FOLLOW_BIT] = ist_next[IRQ_FOLLOW_BIT] | follow_set;
    ist_next[IRQ_RAMP_BIT]   = ist_next[IRQ_RAMP_BIT] | ramp_set;
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:       rdata_next = {29'h0, react_reg};
        REG_STATUS:     rdata_next = {16'h0, status_word};
        REG_IRQ_STAT:   rdata_next = {29'h0, ist_reg};
        REG_IRQ_EN:     rdata_next = {29'h0, ien_reg};
        REG_FE_WINDOW:  rdata_next = fe_win_reg;
        REG_FE_TIMEOUT: rdata_next = {16'h0, fe_to_reg};
        REG_HIST_CNT:   rdata_next = {16'h0, hist_cnt_reg};
        default:
          if (reg_addr >= REG_HIST_BASE)
            rdata_next = {16'h0, hist_reg[3'(reg_addr - REG_HIST_BASE)]};
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      id_eff_reg    <= '0;
      rx_block_reg  <= 1'b0;
      dup_reg       <= 1'b0;
      follow_reg    <= 1'b0;
      ramp_warn_reg <= 1'b0;
      ramp_done_reg <= 1'b0;
      refuse_reg    <= 1'b0;
      dest_reg      <= '0;
      fe_cnt_reg    <= 16'h0000;
      fe_win_reg    <= FE_WINDOW_RST;
      fe_to_reg     <= FE_TIMEOUT_RST;
      react_reg     <= REACT_RST;
      ien_reg       <= IRQ_EN_RST;
      ist_reg       <= 3'h0;
      code_reg      <= EMCY_NONE;
      emcy_reg      <= 1'b0;
      hist_cnt_reg  <= 16'h0000;
      rdata_reg     <= 32'h0000_0000;
      for (int i = 0; i < HIST_DEPTH; i++) begin
        hist_reg[i] <= 16'h0000;
      end
    end else begin
      id_eff_reg    <= id_eff_next;
      rx_block_reg  <= rx_block_next;
      dup_reg       <= dup_next;
      follow_reg    <= follow_next;
      ramp_warn_reg <= ramp_warn_next;
      ramp_done_reg <= ramp_done_next;
      refuse_reg    <= refuse_next;
      dest_reg      <= dest_next;
      fe_cnt_reg    <= fe_cnt_next;
      fe_win_reg    <= fe_win_next;
      fe_to_reg     <= fe_to_next;
      react_reg     <= react_next;
      ien_reg       <= ien_next;
      ist_reg       <= ist_next;
      code_reg      <= code_next;
      emcy_reg      <= emcy_next;
      hist_cnt_reg  <= hist_cnt_next;
      rdata_reg     <= rdata_next;
      // Newest entry at index 0, older ones shift down
      if (hist_push) begin
        hist_reg[0] <= push_code;
        for (int i = 1; i < HIST_DEPTH; i++) begin
          hist_reg[i] <= hist_reg[i-1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign status_word = (16'(follow_reg) << SW_FAULT_BIT) |
                       (16'(follow_reg) << SW_FOLLOW_BIT);
  assign fault_react = follow_reg ? react_reg : 3'h0;
  assign emcy_b0     = code_reg[7:0];
  assign emcy_b1     = code_reg[15:8];
  assign emcy_req    = emcy_reg;
  assign id_eff      = id_eff_reg;
  assign rx_block    = rx_block_reg;
  assign ramp_refuse = refuse_reg;
  assign ramp_dest   = dest_reg;
  assign reg_rdata   = rdata_reg;
  assign irq         = |(ist_reg & ien_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_conflict_block: assert property (@(posedge core_clk) disable iff (!nrst)
    (id_wr || id_load) && id_conflict |=> rx_block && dup_reg)
    else $error("conflict did not block reception");
  chk_load_node: assert property (@(posedge core_clk) disable iff (!nrst)
    id_load |=> id_eff[NODE_BITS-1:0] == $past(node_addr))
    else $error("node address not merged on load");
  chk_dup_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    emcy_sent && emcy_req && code_reg == EMCY_DUP_ID && !dup_set
    |=> !dup_reg)
    else $error("conflict code not cleared after send");
  chk_follow_set: assert property (@(posedge core_clk) disable iff (!nrst)
    !follow_reg && fe_cnt_reg > fe_to_reg |=> follow_reg)
    else $error("following error not raised");
  chk_status_bits: assert property (@(posedge core_clk) disable iff (!nrst)
    follow_reg |-> status_word[13] && status_word[3])
    else $error("status bits missing on fault");
  chk_fault_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    follow_reg && fault_clr |=> !status_word[13] ##0 code_reg != EMCY_FOLLOW)
    else $error("fault flags not cleared");
  chk_ramp_warn: assert property (@(posedge core_clk) disable iff (!nrst)
    ramp_set |=> ramp_warn_reg && ramp_refuse)
    else $error("ramp warning not raised");
  chk_ramp_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    ramp_warn_reg && !ramp_done_reg |=> ramp_warn_reg)
    else $error("ramp warning dropped early");
  chk_emcy_bytes: assert property (@(posedge core_clk) disable iff (!nrst)
    emcy_req |-> {emcy_b1, emcy_b0} == code_reg)
    else $error("emergency byte order wrong");
  cov_dup: cover property (@(posedge core_clk) disable iff (!nrst)
    dup_set ##[1:20] emcy_sent);
  cov_follow: cover property (@(posedge core_clk) disable iff (!nrst)
    follow_set ##[1:50] fault_clr);
  cov_ramp: cover property (@(posedge core_clk) disable iff (!nrst)
    ramp_set ##[1:50] !ramp_warn_reg);

endmodule : dfe_reporter

`default_nettype wire

// [tb.sv]
// Self-checking bench for the fault and emergency reporter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dfe_pkg::*;
  logic core_clk, nrst, reg_wr, reg_rd, id_wr, id_load, id_conflict;
  logic emcy_sent, emcy_req, ramp_req, ramp_ack, incr_mode;
  logic rx_block, ramp_refuse, irq;
  logic [3:0]  reg_addr, delay;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [10:0] id_value, id_eff;
  logic [6:0]  node_addr;
  logic [7:0]  emcy_b0, emcy_b1;
  logic [15:0] status_word, last_code;
  logic [2:0]  fault_react;
  logic signed [31:0] follow_err, ramp_target, ramp_dist, stroke;
  logic signed [31:0] range_min, range_max, soft_min, soft_max, ramp_dest;
  int fails, check_count, cyc;

  dfe_reporter dfe_reporter_i (.core_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .id_wr, .id_load, .id_value, .node_addr,
    .id_conflict, .id_eff, .rx_block, .emcy_sent, .emcy_req, .emcy_b0,
    .emcy_b1, .follow_err, .ramp_req, .ramp_ack, .incr_mode, .ramp_target,
    .ramp_dist, .stroke, .range_min, .range_max, .soft_min, .soft_max,
    .ramp_refuse, .ramp_dest, .status_word, .fault_react, .irq);
  dfe_can_master_model dfe_can_master_model_i (.core_clk, .nrst, .delay,
    .emcy_req, .emcy_b0, .emcy_b1, .emcy_sent, .last_code);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cyc++;
    // Whole run needs well under a thousand cycles
    if (cyc == 5000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : clk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  task automatic idop(input logic ld, input logic cf, input logic [10:0] v);
    @(posedge core_clk);
    id_load     <= ld;
    id_wr       <= !ld;
    id_conflict <= cf;
    id_value    <= v;
    @(posedge core_clk);
    id_wr   <= 1'b0;
    id_load <= 1'b0;
    #1;
  endtask : idop

  task automatic ramp(input logic inc, input int t, input int d);
    @(posedge core_clk);
    incr_mode   <= inc;
    ramp_target <= t;
    ramp_dist   <= d;
    ramp_req    <= 1'b1;
    @(posedge core_clk);
    ramp_req <= 1'b0;
    clk(1);
  endtask : ramp

  task automatic ack_cycle;
    @(posedge core_clk);
    ramp_ack <= 1'b1;
    clk(2);
    check({emcy_b1, emcy_b0}, EMCY_RAMP);
    @(posedge core_clk);
    ramp_ack <= 1'b0;
    clk(2);
    check(emcy_req, 1'b0);
    check({emcy_b1, emcy_b0}, EMCY_NONE);
  endtask : ack_cycle

  task automatic drain;
    for (int i = 0; i < 20 && emcy_req === 1'b1; i++) clk(1);
  endtask : drain

  initial begin
    {nrst, reg_wr, reg_rd, id_wr, id_load, id_conflict} = '0;
    {ramp_req, ramp_ack, incr_mode} = '0;
    {reg_addr, reg_wdata, id_value, node_addr} = '0;
    {follow_err, ramp_target, ramp_dist} = '0;
    delay = 4'h3;
    stroke = 800;
    range_min = -1000;
    range_max = 1000;
    soft_min = -500;
    soft_max = 500;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    rdr(REG_FE_WINDOW, rd); check(rd, FE_WINDOW_RST);
    rdr(REG_FE_TIMEOUT, rd); check(rd, 32'h0000_000a);
    rdr(REG_IRQ_EN, rd); check(rd, 32'h0);
    rdr(REG_IRQ_CLR, rd); check(rd, 32'h0);
    // --------------------------------------------------------------
    // Duplicate identifier, slow master
    // --------------------------------------------------------------
    wr(REG_IRQ_EN, 32'h7);
    idop(1'b0, 1'b1, 11'h181);
    check(rx_block, 1'b1);
    check({emcy_b1, emcy_b0}, EMCY_DUP_ID);
    check(emcy_b0, 8'h50);
    clk(1);
    check(irq, 1'b1);
    drain();
    check(emcy_req, 1'b0);
    check(last_code, EMCY_DUP_ID);
    check(rx_block, 1'b1);
    rdr(REG_IRQ_STAT, rd); check(rd[IRQ_DUP_BIT], 1'b1);
    wr(REG_IRQ_CLR, 32'h7);
    clk(1);
    check(irq, 1'b0);
    idop(1'b0, 1'b0, 11'h7ff);
    check(rx_block, 1'b0);
    check(id_eff, 11'h7ff);
    // Stored id kept in standard form before loading
    delay <= 4'h0;
    node_addr <= 7'h25;
    idop(1'b1, 1'b1, 11'h200);
    check(id_eff, 11'h225);
    check({emcy_b1, emcy_b0}, EMCY_DUP_ID);
    drain();
    // Master restores defaults and resets the node
    nrst <= 1'b0;
    clk(2);
    check(rx_block, 1'b0);
    nrst <= 1'b1;
    rdr(REG_IRQ_STAT, rd); check(rd, 32'h0);
    idop(1'b1, 1'b0, 11'h180);
    check(rx_block, 1'b0);
    check(id_eff, 11'h1a5);
    // --------------------------------------------------------------
    // Following error
    // --------------------------------------------------------------
    wr(REG_CTRL, 32'h3);
    wr(REG_FE_TIMEOUT, 32'h4);
    follow_err <= 300;
    clk(4);
    check(status_word[SW_FOLLOW_BIT], 1'b0);
    for (int i = 0; i < 10 && status_word[SW_FOLLOW_BIT] !== 1'b1; i++)
      clk(1);
    check(status_word & 16'h2008, 16'h2008);
    check(fault_react, 3'h3);
    check({emcy_b1, emcy_b0}, EMCY_FOLLOW);
    rdr(REG_STATUS, rd); check(rd, 32'h0000_2008);
    rdr(REG_HIST_BASE, rd); check(rd[15:0], EMCY_FOLLOW);
    follow_err <= 0;
    wr(REG_CTRL, 32'h103);
    clk(2);
    check(status_word & 16'h2008, 16'h0);
    check(fault_react, 3'h0);
    check(emcy_req, 1'b0);
    check({emcy_b1, emcy_b0}, EMCY_NONE);
    // --------------------------------------------------------------
    // Position ramp limits
    // --------------------------------------------------------------
    ramp(1'b0, 600, 0);
    check(ramp_refuse, 1'b1);
    clk(1);
    check({emcy_b1, emcy_b0}, EMCY_RAMP);
    rdr(REG_IRQ_STAT, rd); check(rd[IRQ_RAMP_BIT], 1'b1);
    ack_cycle();
    ramp(1'b0, 400, 0);
    check(ramp_refuse, 1'b0);
    check(ramp_dest, 400);
    ramp(1'b1, 400, 800);
    check(ramp_refuse, 1'b1);
    clk(1);
    ack_cycle();
    soft_min <= -1000;
    soft_max <= 1000;
    ramp(1'b0, 1100, 0);
    check(ramp_refuse, 1'b0);
    check(ramp_dest, -900);
    rdr(REG_HIST_CNT, rd); check(rd, 32'h3);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
